// File: hdl/ebcr_pkg.sv
// package: register map, field layout and shared types of the bus control block
package ebcr_pkg;
    // register byte address
    localparam logic [31:0] EBCR_CTRL_ADDR = 32'hfff0_1000;
    // reset value of the control register
    localparam logic [31:0] EBCR_CTRL_RESET = 32'h0001_0000;
    // field positions
    localparam int EBCR_BANK_MODE_LSB = 24;
    localparam int EBCR_BANK_MODE_MSB = 27;
    localparam int EBCR_REFRESH_EN_BIT = 18;
    localparam int EBCR_REFRESH_MODE_BIT = 17;
    localparam int EBCR_CKE_BIT = 16;
    localparam int EBCR_PERIOD_LSB = 3;
    localparam int EBCR_PERIOD_MSB = 15;
    localparam int EBCR_WAIT_LSB = 1;
    localparam int EBCR_WAIT_MSB = 2;
    localparam int EBCR_ORDER_BIT = 0;
    // field widths and io bank count
    localparam int EBCR_PERIOD_W = 13;
    localparam int EBCR_NUM_BANKS = 4;
    // writable bits mask (order bit is read only)
    localparam logic [31:0] EBCR_WMASK = 32'h0f07_fffe;

    // decoded control fields
    typedef struct packed {
        logic [3:0] bank_byte_lane_mode;
        logic refresh_enable;
        logic refresh_mode_select;
        logic sdram_clock_enable_ctrl;
        logic [12:0] refresh_period_count;
        logic [1:0] wait_sample_point;
    } ebcr_ctrl_t;

    // external io access request
    typedef struct packed {
        logic valid;
        logic [1:0] bank;
        logic write;
        logic [1:0] byte_sel;
    } ebcr_io_req_t;

    // external io lane pin drive, active low
    typedef struct packed {
        logic [1:0] byte_lane_pins_n;
        logic common_write_strobe_n;
    } ebcr_io_pins_t;
endpackage

// File: hdl/ebcr_refresh_timer.sv
// refresh interval timer: pulses once per programmed period
`timescale 1ns/1ps
module ebcr_refresh_timer #(
    parameter int PERIOD_W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic enable,
    input wire logic [PERIOD_W-1:0] period,
    // refresh request pulse
    output logic tick
);
    logic [PERIOD_W-1:0] count_q; // cycles left in the period
    logic [PERIOD_W-1:0] count_d;
    logic tick_q;
    logic tick_d;

    // next count: hold at reload while off, reload after each tick
    always_comb
    begin
        count_d = count_q;
        tick_d = 1'b0;
        if (!enable)
        begin
            count_d = period;
        end
        else if (count_q <= PERIOD_W'(1))
        begin
            // zero period treated as one cycle so the counter never wraps
            tick_d = 1'b1;
            count_d = period;
        end
        else
        begin
            count_d = count_q - PERIOD_W'(1);
        end
    end

    // register state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule // ebcr_refresh_timer

// File: hdl/ebcr_ctrl.sv
// bus control register with byte-lane steering and sdram refresh control
// Summary of operation
// - one byte-lane mode bit per io bank, bits 27..24
// - mode 1: lanes are byte enables, common strobe writes
// - mode 0: lanes are per-byte write strobes
// - bit 18 enables periodic auto-refresh, clear stops
// - one refresh per refresh-count memory clocks
// - bit 17 selects self-refresh, write 1 enters it
// - any sdram access clears self-refresh bit
// - bit 16 drives sdram clock enable, default one
// - bit 0 reads strapped byte order, read only
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module ebcr_ctrl #(
    parameter int PERIOD_W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // power-on byte order strap
    input wire logic order_strap,
    // sdram activity
    input wire logic sdram_access,
    // external io access
    input wire ebcr_pkg::ebcr_io_req_t io_req,
    output ebcr_pkg::ebcr_io_pins_t io_pins,
    // sdram control outputs
    output logic sdram_cke,
    output logic sdram_refresh_req,
    output logic sdram_self_refresh,
    output logic [1:0] wait_sample_point
);
    ebcr_pkg::ebcr_ctrl_t ctrl_q; // stored control fields
    ebcr_pkg::ebcr_ctrl_t ctrl_d;
    logic order_q; // latched byte order
    logic order_d;
    logic strap_taken_q; // strap caught once after reset
    logic strap_taken_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    ebcr_pkg::ebcr_io_pins_t pins_q;
    ebcr_pkg::ebcr_io_pins_t pins_d;
    logic cke_q;
    logic cke_d;
    logic self_q;
    logic self_d;
    logic refresh_q;
    logic refresh_d;
    logic tick; // interval elapsed
    logic hit; // address matches control register
    logic [31:0] ctrl_word; // readback image
    logic [3:0] lane_mode; // per-bank byte-lane mode

    assign hit = (reg_addr == ebcr_pkg::EBCR_CTRL_ADDR);

    // per-bank byte-lane mode bits
    genvar gi;
    generate
        for (gi = 0; gi < ebcr_pkg::EBCR_NUM_BANKS; gi++)
        begin : g_lane
            assign lane_mode[gi] = ctrl_q.bank_byte_lane_mode[gi];
        end
    endgenerate

    // readback image; reserved bits read zero
    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[ebcr_pkg::EBCR_BANK_MODE_MSB:ebcr_pkg::EBCR_BANK_MODE_LSB] = lane_mode;
        ctrl_word[ebcr_pkg::EBCR_REFRESH_EN_BIT] = ctrl_q.refresh_enable;
        ctrl_word[ebcr_pkg::EBCR_REFRESH_MODE_BIT] = ctrl_q.refresh_mode_select;
        ctrl_word[ebcr_pkg::EBCR_CKE_BIT] = ctrl_q.sdram_clock_enable_ctrl;
        ctrl_word[ebcr_pkg::EBCR_PERIOD_MSB:ebcr_pkg::EBCR_PERIOD_LSB] =
            ctrl_q.refresh_period_count;
        ctrl_word[ebcr_pkg::EBCR_WAIT_MSB:ebcr_pkg::EBCR_WAIT_LSB] = ctrl_q.wait_sample_point;
        ctrl_word[ebcr_pkg::EBCR_ORDER_BIT] = order_q;
    end

    // register writes and hardware clear of self-refresh
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (reg_write && hit)
        begin
            ctrl_d.bank_byte_lane_mode =
                reg_wdata[ebcr_pkg::EBCR_BANK_MODE_MSB:ebcr_pkg::EBCR_BANK_MODE_LSB];
            ctrl_d.refresh_enable = reg_wdata[ebcr_pkg::EBCR_REFRESH_EN_BIT];
            ctrl_d.refresh_mode_select = reg_wdata[ebcr_pkg::EBCR_REFRESH_MODE_BIT];
            ctrl_d.sdram_clock_enable_ctrl = reg_wdata[ebcr_pkg::EBCR_CKE_BIT];
            ctrl_d.refresh_period_count =
                reg_wdata[ebcr_pkg::EBCR_PERIOD_MSB:ebcr_pkg::EBCR_PERIOD_LSB];
            ctrl_d.wait_sample_point = reg_wdata[ebcr_pkg::EBCR_WAIT_MSB:ebcr_pkg::EBCR_WAIT_LSB];
        end
        // an sdram access wins over a same-cycle write of self-refresh,
        // since the memory is already awake by then
        if (sdram_access)
        begin
            ctrl_d.refresh_mode_select = 1'b0;
        end
    end

    // strap capture: taken on the first clock after reset release
    always_comb
    begin
        order_d = order_q;
        strap_taken_d = 1'b1;
        if (!strap_taken_q)
        begin
            order_d = order_strap;
        end
    end

    // read data, one cycle after the strobe, only then
    always_comb
    begin
        rdata_d = '0;
        if (reg_read && hit)
        begin
            rdata_d = ctrl_word;
        end
    end

    // byte-lane pin drive for io accesses (active low)
    always_comb
    begin
        pins_d.byte_lane_pins_n = 2'b11;
        pins_d.common_write_strobe_n = 1'b1;
        if (io_req.valid)
        begin
            if (lane_mode[io_req.bank])
            begin
                // lanes select bytes on read and write, strobe marks the write
                pins_d.byte_lane_pins_n = ~io_req.byte_sel;
                pins_d.common_write_strobe_n = ~io_req.write;
            end
            else if (io_req.write)
            begin
                // lanes act as write strobes; reads leave them idle
                pins_d.byte_lane_pins_n = ~io_req.byte_sel;
            end
        end
    end

    // sdram control outputs
    always_comb
    begin
        cke_d = ctrl_d.sdram_clock_enable_ctrl;
        self_d = ctrl_d.refresh_mode_select;
        // auto-refresh only in auto mode with refresh on
        refresh_d = tick && ctrl_q.refresh_enable && !ctrl_q.refresh_mode_select;
    end

    // interval timer
    ebcr_refresh_timer #(
        .PERIOD_W(PERIOD_W)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .enable(ctrl_q.refresh_enable && !ctrl_q.refresh_mode_select),
        .period(ctrl_q.refresh_period_count),
        .tick(tick)
    );

    // register all state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_q <= '0;
            ctrl_q.sdram_clock_enable_ctrl <= 1'b1;
            order_q <= 1'b0;
            strap_taken_q <= 1'b0;
            rdata_q <= '0;
            pins_q <= '1;
            cke_q <= 1'b1;
            self_q <= 1'b0;
            refresh_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            order_q <= order_d;
            strap_taken_q <= strap_taken_d;
            rdata_q <= rdata_d;
            pins_q <= pins_d;
            cke_q <= cke_d;
            self_q <= self_d;
            refresh_q <= refresh_d;
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_q;
    assign io_pins = pins_q;
    assign sdram_cke = cke_q;
    assign sdram_self_refresh = self_q;
    assign sdram_refresh_req = refresh_q;
    assign wait_sample_point = ctrl_q.wait_sample_point;
endmodule // ebcr_ctrl

// File: tb/ebcr_chk.sv
// checker: port-level assertions for the bus control block
`timescale 1ns/1ps
module ebcr_chk #(
    parameter int PERIOD_W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // strap and sdram activity
    input wire logic order_strap,
    input wire logic sdram_access,
    // io lanes
    input wire ebcr_pkg::ebcr_io_req_t io_req,
    input wire ebcr_pkg::ebcr_io_pins_t io_pins,
    // sdram controls
    input wire logic sdram_cke,
    input wire logic sdram_refresh_req,
    input wire logic sdram_self_refresh,
    input wire logic [1:0] wait_sample_point
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // write hit on the control word
    logic hit_w;
    assign hit_w = reg_write && reg_addr == ebcr_pkg::EBCR_CTRL_ADDR;
    AST_RDATA_IDLE:
        assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero without a read");
    AST_ORDER_RO:
        assert property (reg_read |=> reg_rdata[0] == (reg_addr == 32'hfff0_1000
        && $past(order_strap))) else $error("order bit wrong");
    AST_CKE_WRITE:
        assert property (hit_w |=> sdram_cke == $past(reg_wdata[16]))
        else $error("clock enable does not follow write");
    AST_SELF_SET:
        assert property (hit_w && reg_wdata[17] && !sdram_access
        |=> sdram_self_refresh) else $error("self refresh not entered");
    AST_SELF_CLR:
        assert property (sdram_access |=> !sdram_self_refresh)
        else $error("access did not leave self refresh");
    AST_SELF_QUIET:
        assert property (sdram_self_refresh [*2] |-> !sdram_refresh_req)
        else $error("refresh pulse in self refresh");
    AST_REF_OFF:
        assert property (hit_w && !reg_wdata[18] |=> ##1 !sdram_refresh_req [*3])
        else $error("refresh pulse after disable");
    AST_IO_IDLE:
        assert property (!io_req.valid |=> io_pins == 3'b111)
        else $error("lane pins active while idle");
    AST_IO_READ:
        assert property (io_req.valid && !io_req.write
        |=> io_pins.common_write_strobe_n) else $error("strobe on read");
    AST_IO_WRITE:
        assert property (io_req.valid && io_req.write |=> io_pins.byte_lane_pins_n
        == ~$past(io_req.byte_sel)) else $error("lanes wrong on write");
endmodule // ebcr_chk

bind ebcr_ctrl ebcr_chk #(.PERIOD_W(PERIOD_W)) i_chk (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .order_strap(order_strap), .sdram_access(sdram_access),
    .io_req(io_req), .io_pins(io_pins), .sdram_cke(sdram_cke),
    .sdram_refresh_req(sdram_refresh_req), .sdram_self_refresh(sdram_self_refresh),
    .wait_sample_point(wait_sample_point));

// File: tb/ebcr_partner.sv
// far-side model: sdram that tallies refreshes and makes accesses on demand
`timescale 1ns/1ps
module ebcr_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // requests from bench and device
    input wire logic access_go,
    input wire logic refresh_req,
    // sdram activity and tally
    output logic sdram_access,
    output int n_refresh
);
    // one access cycle per request; refreshes counted for the bench
    always_ff @(posedge clk)
    begin
        sdram_access <= !rst && access_go;
        n_refresh <= rst ? 0 : n_refresh + int'(refresh_req);
    end
endmodule // ebcr_partner

// File: tb/ebcr_ctrl_bench.sv
// bench: register, lane and refresh checks against a reference model
`timescale 1ns/1ps
module ebcr_ctrl_bench;
    // stimulus and model state
    logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, order_strap = 1, access_go = 0;
    logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata, m = 32'h0001_0001, r;
    logic [31:0] seed = 32'h7fb4_af9a;
    ebcr_pkg::ebcr_io_req_t io_req = '0;
    ebcr_pkg::ebcr_io_pins_t io_pins, ex;
    logic sdram_access, sdram_cke, sdram_refresh_req, sdram_self_refresh;
    logic [1:0] wait_sample_point;
    int n_fail = 0, checks = 0, cyc = 0, n_refresh, last, n0;
    localparam logic [31:0] A = ebcr_pkg::EBCR_CTRL_ADDR;
    always #2.5 clk = ~clk;
    ebcr_ctrl #(.PERIOD_W(13)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .order_strap(order_strap), .sdram_access(sdram_access),
        .io_req(io_req), .io_pins(io_pins), .sdram_cke(sdram_cke),
        .sdram_refresh_req(sdram_refresh_req), .sdram_self_refresh(sdram_self_refresh),
        .wait_sample_point(wait_sample_point));
    ebcr_partner i_far (.clk(clk), .rst(rst), .access_go(access_go),
        .refresh_req(sdram_refresh_req), .sdram_access(sdram_access), .n_refresh(n_refresh));
    // xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected lanes: mode 1 enables, mode 0 per-byte strobes
    function automatic ebcr_pkg::ebcr_io_pins_t io_exp(ebcr_pkg::ebcr_io_req_t q);
        logic md;
        md = m[24 + q.bank];
        if (!q.valid)
            return 3'b111;
        return {(md || q.write) ? ~q.byte_sel : 2'b11, md ? ~q.write : 1'b1};
    endfunction
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [31:0] a, logic [31:0] d);
        @(posedge clk);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_write <= 0;
        if (a == A)
            m = (m & ~ebcr_pkg::EBCR_WMASK) | (d & ebcr_pkg::EBCR_WMASK);
    endtask
    task automatic rd(logic [31:0] a, logic [31:0] exp);
        @(posedge clk);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_read <= 0;
        #1 cmp(reg_rdata, exp);
    endtask
    // pulse spacing must equal the programmed count
    task automatic gaps(int n);
        last = 0;
        n0 = n_refresh;
        repeat (10 * n)
        begin
            @(posedge clk);
            #1;
            if (sdram_refresh_req === 1'b1 && last != 0)
                cmp(32'(cyc - last), 32'(n));
            if (sdram_refresh_req === 1'b1)
                last = cyc;
        end
        cmp(32'(n_refresh - n0 >= 9), 1);
    endtask
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // cycle count and hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 0;
        rd(A, m);
        wr(32'hfff0_1004, '1);
        rd(32'hfff0_1004, 0);
        wr(A, '1);
        rd(A, m);
        for (int k = 0; k < 16; k++)
        begin
            wr(A, {4'h0, 4'(k), 24'h01_0000});
            repeat (12)
            begin
                ex = io_exp(io_req);
                r = rnd();
                @(posedge clk);
                io_req <= r[5:0];
                #1 cmp(io_pins, ex);
            end
        end
        wr(A, 32'h0005_0020);
        gaps(4);
        wr(A, 32'h0001_0020);
        repeat (2) @(posedge clk);
        n0 = n_refresh;
        repeat (30) @(posedge clk);
        cmp(n_refresh, n0);
        wr(A, 32'h0005_0030);
        gaps(6);
        wr(A, 32'h0007_0020);
        repeat (2) @(posedge clk);
        n0 = n_refresh;
        repeat (20) @(posedge clk);
        #1 cmp(32'(sdram_self_refresh), 1);
        cmp(n_refresh, n0);
        @(posedge clk);
        access_go <= 1;
        @(posedge clk);
        access_go <= 0;
        m[17] = 0;
        repeat (2) @(posedge clk);
        #1 cmp(sdram_self_refresh, 0);
        rd(A, m);
        wr(A, 32'h0000_0006);
        #1 cmp({sdram_cke, wait_sample_point}, 3'b011);
        wr(A, 32'h0001_0000);
        #1 cmp(sdram_cke, 1);
        // second reset with the strap low: bit 0 must now read zero
        @(posedge clk);
        {rst, order_strap} <= 2'b10;
        repeat (3) @(posedge clk);
        rst <= 0;
        m = 32'h0001_0000;
        rd(A, m);
        wrap_up();
    end
endmodule // ebcr_ctrl_bench
